//--- core/pic_pkg.sv
// Purpose : Constants and types for the PHY interrupt and control block
// Assumes : APB byte address is four times the register index
// Notes   : Registers are 16 bits wide in the low half of the data word
package pic_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  IDX_CTRL     = 8'h11;
  localparam logic [7:0]  IDX_STAT     = 8'h12;
  localparam logic [7:0]  ADDR_CTRL    = 8'h44;
  localparam logic [7:0]  ADDR_STAT    = 8'h48;

  // ==========================================================
  // Control field positions and values
  localparam int          B_PSM_HI     = 13;
  localparam int          B_PSM_LO     = 12;
  localparam int          B_DEPTH_HI   = 9;
  localparam int          B_DEPTH_LO   = 8;
  localparam int          B_COL_FD     = 4;
  localparam int          B_POL        = 3;
  localparam int          B_TEST       = 2;
  localparam int          B_GEN_EN     = 1;
  localparam int          B_OUT_EN     = 0;
  localparam logic [1:0]  PSM_NORMAL   = 2'h0;
  localparam logic [1:0]  PSM_PASSIVE  = 2'h3;
  localparam logic [1:0]  DEPTH_RST    = 2'h1;
  localparam logic        POL_RST      = 1'h1;

  // ==========================================================
  // Status events, bit n of the event vector sits at status bit n+8
  localparam int          N_EVT        = 8;
  localparam int          E_QUAL       = 7;
  localparam int          E_ENERGY     = 6;
  localparam int          E_LINK       = 5;
  localparam int          E_SPEED      = 4;
  localparam int          E_DUPLEX     = 3;
  localparam int          E_ANEG       = 2;
  localparam int          E_FC_HF      = 1;
  localparam int          E_RX_HF      = 0;
  localparam logic [7:0]  HF_LIMIT     = 8'h7F;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [1:0] psm;
    logic [1:0] depth;
    logic       col_fd;
    logic       pol;
    logic       test;
    logic       gen_en;
    logic       out_en;
  } pic_ctrl_t;

  typedef struct packed {
    logic       qual_ok;
    logic       energy;
    logic       link_up;
    logic       speed;
    logic       duplex;
    logic       aneg_done;
    logic       fc_hf;
    logic       rx_hf;
  } pic_line_t;

  typedef struct packed {
    pic_ctrl_t    ctrl;
    logic [7:0]   stat;
    logic [7:0]   en;
    pic_line_t    prev;
    logic         sleep;
    logic [2:0]   sync;
    logic         pwdn_lvl;
    logic [31:0]  rdata;
    logic         slverr;
    logic [7:0]   cap;
  } pic_state_t;

endpackage

//--- core/pic_top.sv
// Purpose : Interrupt status, masking and PHY specific control over APB
// Assumes : Line status and counters come from logic on core_clk
// Notes   : Zero wait state APB slave, read data captured in setup
//
// Overview of operation
// - Power mode code 11 enters passive sleep; wakes when energy detected
// - Bits 9:8 set loopback FIFO depth, reset 01, five nibbles
// - With bit 4 clear, no collision signalling in full duplex
// - Bit 3 selects pin polarity; default idles high, drives low
// - Test bit forces interrupt until cleared
// - Bit 1 gates event interrupts by per-event enables in status
// - Bit 0 makes shared pin an interrupt output, else power-down input
// - Status bit 15 latches link quality change while link up
// - Status bit 14 latches energy detect change
// - Status bit 13 latches link status change either way
// - Status bit 12 latches speed change
// - Status bit 11 latches duplex change
// - Status bit 10 latches auto-negotiation completion
// - Status bit 9 latches false carrier counter half-full
// - Status bit 8 latches receive error counter half-full
// - Enable bit 7 unmasks link quality event, resets 0
// - Enable bit 6 unmasks energy event, resets 0
// - Counter above 7Fh is half-full and raises its event
// - Bits 5..0 enable link, speed, duplex, aneg, carrier, rx error
`timescale 1ns/1ps
module pic_top
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Line status from the PHY core
  input  wire pic_line_t   line_i,
  input  wire logic [7:0]  fc_count,
  input  wire logic [7:0]  rx_err_count,
  input  wire logic        col_raw,
  // Shared interrupt or power-down pin
  input  wire logic        irq_pin_i,
  output logic             irq_pin_o,
  output logic             irq_pin_oe,
  // Control outputs to the PHY core
  output logic             passive_sleep,
  output logic             pwdn_req,
  output logic [1:0]       lb_fifo_depth,
  output logic             col_out,
  output logic             irq_active
);

  // ==========================================================
  // Helpers
  function automatic logic is_hf(input logic [7:0] cnt);
    is_hf = (cnt > HF_LIMIT);
  endfunction

  function automatic logic [15:0] ctrl_word(input pic_ctrl_t c);
    logic [15:0] w;
    w = '0;
    w[B_PSM_HI:B_PSM_LO]     = c.psm;
    w[B_DEPTH_HI:B_DEPTH_LO] = c.depth;
    w[B_COL_FD]              = c.col_fd;
    w[B_POL]                 = c.pol;
    w[B_TEST]                = c.test;
    w[B_GEN_EN]              = c.gen_en;
    w[B_OUT_EN]              = c.out_en;
    ctrl_word = w;
  endfunction

  // ==========================================================
  // State
  pic_state_t  s_q;
  pic_state_t  s_d;
  pic_line_t   cur;
  logic [7:0]  evt;
  logic        setup_ph;
  logic        access_ph;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [7:0]  clr;

  always_comb
  begin
    cur       = line_i;
    cur.fc_hf = is_hf(fc_count);
    cur.rx_hf = is_hf(rx_err_count);
  end

  // ==========================================================
  // Event detection
  always_comb
  begin
    evt           = '0;
    // Quality changes only count while the link is up in the current sample
    evt[E_QUAL]   = (cur.qual_ok != s_q.prev.qual_ok) &&
                    cur.link_up;
    evt[E_ENERGY] = cur.energy != s_q.prev.energy;
    evt[E_LINK]   = cur.link_up != s_q.prev.link_up;
    evt[E_SPEED]  = cur.speed != s_q.prev.speed;
    evt[E_DUPLEX] = cur.duplex != s_q.prev.duplex;
    evt[E_ANEG]   = cur.aneg_done && !s_q.prev.aneg_done;
    evt[E_FC_HF]  = cur.fc_hf && !s_q.prev.fc_hf;
    evt[E_RX_HF]  = cur.rx_hf && !s_q.prev.rx_hf;
  end

  // ==========================================================
  // APB decode
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr == ADDR_CTRL)
      hit_ctrl = 1'b1;
    else if (paddr == ADDR_STAT)
      hit_stat = 1'b1;
  end

  // Only bits shown to software are cleared, so a late event survives
  assign clr = (access_ph && !pwrite && hit_stat) ? s_q.cap : '0;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d      = s_q;
    s_d.prev = cur;
    s_d.stat = (s_q.stat & ~clr) | evt;

    // Read data is fixed in setup, the access edge only completes it
    if (setup_ph)
    begin
      s_d.rdata  = '0;
      s_d.slverr = 1'b0;
      s_d.cap    = '0;
      if (hit_ctrl)
        s_d.rdata[15:0] = ctrl_word(s_q.ctrl);
      else if (hit_stat)
      begin
        s_d.rdata[15:0] = {s_q.stat, s_q.en};
        s_d.cap         = s_q.stat;
      end
      else
        s_d.slverr = 1'b1;
    end

    if (access_ph && pwrite && hit_ctrl)
    begin
      s_d.ctrl.psm    = pwdata[B_PSM_HI:B_PSM_LO];
      s_d.ctrl.depth  = pwdata[B_DEPTH_HI:B_DEPTH_LO];
      s_d.ctrl.col_fd = pwdata[B_COL_FD];
      s_d.ctrl.pol    = pwdata[B_POL];
      s_d.ctrl.test   = pwdata[B_TEST];
      s_d.ctrl.gen_en = pwdata[B_GEN_EN];
      s_d.ctrl.out_en = pwdata[B_OUT_EN];
    end
    else if (access_ph && pwrite && hit_stat)
      s_d.en = pwdata[7:0];

    // Passive sleep, left by hardware once a partner shows energy
    if (s_q.sleep && cur.energy)
    begin
      s_d.sleep    = 1'b0;
      s_d.ctrl.psm = PSM_NORMAL;
    end
    else
      s_d.sleep = (s_d.ctrl.psm == PSM_PASSIVE);

    // Pin taken through three flops, level moves when last two agree
    s_d.sync = {s_q.sync[1:0], irq_pin_i};
    if (s_q.sync[1] == s_q.sync[2])
      s_d.pwdn_lvl = s_q.sync[2];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q            <= '0;
      s_q.ctrl.depth <= DEPTH_RST;
      s_q.ctrl.pol   <= POL_RST;
      s_q.sync       <= 3'h7;
      s_q.pwdn_lvl   <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs
  assign irq_active = s_q.ctrl.test ||
                      (s_q.ctrl.gen_en && |(s_q.stat & s_q.en));
  assign irq_pin_oe = s_q.ctrl.out_en;
  // Default polarity drives the pin low for an interrupt
  assign irq_pin_o  = s_q.ctrl.pol ? !irq_active : irq_active;
  assign pwdn_req   = !s_q.ctrl.out_en && !s_q.pwdn_lvl;
  assign passive_sleep = s_q.sleep;
  assign lb_fifo_depth = s_q.ctrl.depth;
  assign col_out    = col_raw && (!line_i.duplex || s_q.ctrl.col_fd);
  assign prdata     = s_q.rdata;
  assign pready     = access_ph;
  assign pslverr    = access_ph && s_q.slverr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_test_irq: assert property (s_q.ctrl.test |-> irq_active)
    else $error("test bit set without interrupt");

  a_global_gate: assert property
    (!s_q.ctrl.gen_en && !s_q.ctrl.test |-> !irq_active)
    else $error("interrupt without global enable");

  a_pin_level: assert property
    (s_q.ctrl.out_en && s_q.ctrl.pol && irq_active
     |-> irq_pin_oe && !irq_pin_o)
    else $error("active interrupt not driven low");

  a_fd_col: assert property
    (line_i.duplex && !s_q.ctrl.col_fd |-> !col_out)
    else $error("collision in full duplex while disabled");

  a_link_latch: assert property
    ($changed(line_i.link_up) |=> s_q.stat[E_LINK] [*2])
    else $error("link change not latched");

  a_hf_latch: assert property
    ($rose(is_hf(fc_count)) |=> s_q.stat[E_FC_HF])
    else $error("false carrier half-full not latched");

  a_rd_clear: assert property
    (access_ph && !pwrite && hit_stat && s_q.cap[E_ANEG] &&
     !evt[E_ANEG] |=> !s_q.stat[E_ANEG])
    else $error("status bit not cleared by read");

  a_sleep_exit: assert property
    (s_q.sleep && line_i.energy |=> !passive_sleep ##1
     (s_q.ctrl.psm == PSM_NORMAL))
    else $error("passive sleep not left on energy");

  a_bad_addr: assert property
    (setup_ph && !hit_ctrl && !hit_stat |=> pslverr && pready)
    else $error("unmapped access without error");

  a_irq_source: assert property
    (s_q.ctrl.gen_en && |(s_q.stat & s_q.en) |-> irq_active)
    else $error("enabled event did not raise interrupt");

  // ==========================================================
  // Assertions on latching, pin roles and control fields
  // Latch checks compare against the last sample, as the logic does
  a_sleep_entry: assert property
    (access_ph && pwrite && hit_ctrl && !s_q.sleep &&
     (pwdata[B_PSM_HI:B_PSM_LO] == PSM_PASSIVE) |=> passive_sleep)
    else $error("passive sleep not entered");

  a_depth_out: assert property
    (access_ph && pwrite && hit_ctrl
     |=> lb_fifo_depth == $past(pwdata[B_DEPTH_HI:B_DEPTH_LO]))
    else $error("fifo depth not taken from write");

  a_col_pass: assert property
    (col_raw && !line_i.duplex |-> col_out)
    else $error("half duplex collision lost");

  a_pin_idle: assert property
    (s_q.ctrl.pol && !irq_active |-> irq_pin_o)
    else $error("idle pin not high with default polarity");

  a_pin_inv: assert property
    (!s_q.ctrl.pol |-> irq_pin_o == irq_active)
    else $error("inverted polarity level wrong");

  a_pwdn_block: assert property
    (irq_pin_oe |-> !pwdn_req)
    else $error("power-down requested while pin is output");

  a_pwdn_follow: assert property
    (!s_q.ctrl.out_en && !s_q.pwdn_lvl |-> pwdn_req)
    else $error("power-down input ignored");

  a_qual_latch: assert property
    ($changed(line_i.qual_ok) && line_i.link_up |=> s_q.stat[E_QUAL])
    else $error("quality change not latched");

  a_qual_down: assert property
    ($changed(line_i.qual_ok) && !line_i.link_up && !s_q.stat[E_QUAL]
     |=> !s_q.stat[E_QUAL])
    else $error("quality event latched with link down");

  a_energy_latch: assert property
    ($changed(line_i.energy) |=> s_q.stat[E_ENERGY])
    else $error("energy change not latched");

  a_speed_latch: assert property
    ($changed(line_i.speed) |=> s_q.stat[E_SPEED])
    else $error("speed change not latched");

  a_duplex_latch: assert property
    ($changed(line_i.duplex) |=> s_q.stat[E_DUPLEX])
    else $error("duplex change not latched");

  a_aneg_latch: assert property
    ($rose(line_i.aneg_done) |=> s_q.stat[E_ANEG])
    else $error("auto-negotiation completion not latched");

  a_rx_hf_latch: assert property
    ($rose(is_hf(rx_err_count)) |=> s_q.stat[E_RX_HF])
    else $error("receive error half-full not latched");

  a_hf_limit: assert property
    (!is_hf(fc_count) && !s_q.stat[E_FC_HF] |=> !s_q.stat[E_FC_HF])
    else $error("half-full latched at or below limit");

  a_en_write: assert property
    (access_ph && pwrite && hit_stat |=> s_q.en == $past(pwdata[7:0]))
    else $error("event enables not written");

  a_late_event: assert property
    (access_ph && !pwrite && hit_stat && evt[E_LINK]
     |=> s_q.stat[E_LINK])
    else $error("event during read was lost");

  a_stat_hold: assert property
    (s_q.stat[E_SPEED] && !(access_ph && !pwrite && hit_stat)
     |=> s_q.stat[E_SPEED])
    else $error("latched status dropped without read");

endmodule

//--- dv/pic_mgr.sv
// Purpose : Management controller model, APB master for the block
// Assumes : One transfer at a time, called by the bench
// Notes   : Released address and data show the inverse, not stale values
`timescale 1ns/1ps
module pic_mgr
(
  // Clock
  input  wire logic        core_clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- dv/tb_pic_top.sv
// Purpose : Self-checking bench for the interrupt and control block
// Assumes : Zero wait state slave, events latch one edge after change
// Notes   : Enables stay 0xFF through the event walk
`timescale 1ns/1ps
module tb_pic_top
  import pic_pkg::*;
;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, fc_count, rx_err_count;
  logic [31:0] pwdata, prdata, r;
  logic        col_raw, irq_pin_i, irq_pin_o, irq_pin_oe, e;
  logic        passive_sleep, pwdn_req, col_out, irq_active;
  logic [1:0]  lb_fifo_depth;
  pic_line_t   line_i;
  int          n_fail, checks_done, cyc;

  pic_mgr pic_mgr_inst (.core_clk(core_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pic_top pic_top_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_i(line_i),
    .fc_count(fc_count), .rx_err_count(rx_err_count), .col_raw(col_raw),
    .irq_pin_i(irq_pin_i), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
    .passive_sleep(passive_sleep), .pwdn_req(pwdn_req),
    .lb_fifo_depth(lb_fifo_depth), .col_out(col_out),
    .irq_active(irq_active));

  // ==========================================================
  // Helpers
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  task automatic stp(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    pic_mgr_inst.xfer(1'h0, a, 32'h0, r, e);
    chk(nm, r, x);
  endtask

  // Extra edge lets the written value reach the outputs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    pic_mgr_inst.xfer(1'h1, a, d, r, e);
    stp(1);
  endtask

  task automatic ev(input int b);
    stp(2);
    rd(ADDR_STAT, 32'hFF | (32'h1 << b), "evt");
    rd(ADDR_STAT, 32'hFF, "clr");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("pin_o", irq_pin_o, 1'h1);
    chk("pin_oe", irq_pin_oe, 1'h0);
    chk("depth", lb_fifo_depth, 2'h1);
    rd(ADDR_CTRL, 32'h0108, "ctrl");
    rd(ADDR_STAT, 32'h0, "stat");
    pic_mgr_inst.xfer(1'h0, 8'h4C, 32'h0, r, e);
    chk("slverr", e, 1'h1);
  endtask

  task automatic t_events();
    int el[4];
    el = '{E_ENERGY, E_LINK, E_SPEED, E_DUPLEX};
    wr(ADDR_CTRL, 32'h010B);
    wr(ADDR_STAT, 32'hFFFF);
    rd(ADDR_STAT, 32'hFF, "en");
    foreach (el[i])
    begin
      @(posedge core_clk);
      line_i[el[i]] <= ~line_i[el[i]];
      stp(2);
      chk("irq", irq_active, 1'h1);
      chk("pin", {irq_pin_oe, irq_pin_o}, 2'h2);
      ev(el[i] + 8);
    end
    line_i.qual_ok <= 1'h1;
    ev(15);
    line_i.aneg_done <= 1'h1;
    ev(10);
    fc_count <= 8'h7F;
    stp(2);
    rd(ADDR_STAT, 32'hFF, "hf");
    fc_count <= 8'h80;
    ev(9);
    rx_err_count <= 8'h80;
    ev(8);
  endtask

  task automatic t_mask();
    wr(ADDR_STAT, 32'h0);
    line_i.speed <= ~line_i.speed;
    stp(2);
    chk("masked", irq_active, 1'h0);
    wr(ADDR_STAT, 32'h10);
    chk("unmask", irq_active, 1'h1);
    wr(ADDR_CTRL, 32'h0109);
    chk("gen_off", irq_active, 1'h0);
    wr(ADDR_CTRL, 32'h0105);
    chk("test", irq_active, 1'h1);
    chk("pol0", irq_pin_o, 1'h1);
    wr(ADDR_CTRL, 32'h0101);
    chk("test_off", irq_active, 1'h0);
    rd(ADDR_STAT, 32'h1010, "pend");
  endtask

  task automatic t_misc();
    col_raw <= 1'h1;
    stp(1);
    chk("col_fd0", col_out, 1'h0);
    wr(ADDR_CTRL, 32'h0110);
    chk("col_fd1", col_out, 1'h1);
    line_i.energy <= 1'h0;
    wr(ADDR_CTRL, 32'h3108);
    stp(3);
    chk("sleep", passive_sleep, 1'h1);
    line_i.energy <= 1'h1;
    stp(3);
    chk("wake", passive_sleep, 1'h0);
    rd(ADDR_CTRL, 32'h0108, "psm");
    irq_pin_i <= 1'h0;
    stp(6);
    chk("pwdn", pwdn_req, 1'h1);
    irq_pin_i <= 1'h1;
    stp(6);
    chk("pwdn_off", pwdn_req, 1'h0);
  endtask

  // ==========================================================
  // Clock, reset, sequence and hang guard
  initial
  begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    rstn = 1'h0;
    line_i = '0;
    fc_count = 8'h00;
    rx_err_count = 8'h00;
    col_raw = 1'h0;
    irq_pin_i = 1'h1;
    stp(3);
    rstn <= 1'h1;
    stp(1);
    t_reset();
    t_events();
    t_mask();
    t_misc();
    close_out();
  end
endmodule
